// file: logic/virc_arbiter.sv
// priority pick among sixteen request lines
// assumes pending and level vectors come from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module virc_arbiter #(
    parameter int NSRC = 16
) (
    // inputs
    input wire logic [NSRC-1:0] pend_i,
    input wire logic [2*NSRC-1:0] level_i,
    // outputs
    output logic found_o,
    output logic [3:0] idx_o
);
    import virc_pkg::*;

    // the four-bit index cannot name more than sixteen lines
    if (NSRC > 16 || NSRC < 1) begin : g_bad_nsrc
        $error("virc_arbiter: NSRC must be 1..16");
    end

    // scan indices high to low; lower index wins ties
    always_comb begin
        logic [1:0] best;
        logic [1:0] lv;
        best = 2'h0;
        lv = 2'h0;
        found_o = 1'b0;
        idx_o = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            lv = level_i[2*i +: 2];
            if (pend_i[i] && lv != 2'h0 && lv >= best) begin
                best = lv;
                found_o = 1'b1;
                idx_o = 4'(i);
            end
        end
    end
endmodule

`default_nettype wire

// file: logic/virc_map.svh
// register offsets, field positions and reset values for the interrupt
// request controller; definitions only, included by the package users
//
// Summary of operation
// - a source request sets its pending bit to one
// - with global enable set, pending enabled requests interrupt the cpu
// - with global enable clear, no cpu signal; pending bits stay readable
// - bank0: timer1 bit6, timer0 bit5, rx bit4, tx bit3, adc bit0
// - flag one means request awaiting service, zero means none
// - enable pair decodes 00 off, 01 low, 10 medium, 11 high
// - pin high and low enable bits live in two registers, bit x each
// - pin 7 shared with low-voltage detector, pin 6 with comparator
// - watchdog and oscillator-fail traps are not handled here
`ifndef VIRC_MAP_SVH
`define VIRC_MAP_SVH

`define VIRC_OFS_PEND0 12'hFC0
`define VIRC_OFS_PEND1 12'hFC3
`define VIRC_OFS_PHI0 12'hFC1
`define VIRC_OFS_PLO0 12'hFC2
`define VIRC_OFS_PINHI 12'hFC4
`define VIRC_OFS_PINLO 12'hFC5
`define VIRC_OFS_SSEL 12'hFC6
`define VIRC_OFS_GCTL 12'hFC7
`define VIRC_OFS_IMASK 12'hFC8
`define VIRC_BIT_T1 6
`define VIRC_BIT_T0 5
`define VIRC_BIT_RX 4
`define VIRC_BIT_TX 3
`define VIRC_BIT_ADC 0
`define VIRC_BANK0_MASK 8'h79
`define VIRC_SSEL_MASK 8'hC0
`define VIRC_RST_BYTE 8'h00

`endif

// file: logic/virc_pkg.sv
// types shared by the interrupt request controller files
// assumes the map header for numeric constants
`default_nettype none

package virc_pkg;
    typedef enum logic [1:0] {
        VIRC_OFF,
        VIRC_LOW,
        VIRC_MED,
        VIRC_HIGH
    } virc_level_t;

    // register port request carried as one word
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } virc_req_t;

    // vector presented to the cpu
    typedef struct packed {
        logic valid;
        logic [3:0] source;
    } virc_vec_t;
endpackage

`default_nettype wire

// file: logic/virc_top.sv
// interrupt request capture, priority decode and cpu vector request
// assumes sources are one-cycle pulses on core_clk_i, pins arrive raw
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "virc_map.svh"

module virc_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // peripheral events, same clock domain
    input wire logic second_timer_request_i,
    input wire logic first_timer_request_i,
    input wire logic serial_receive_request_i,
    input wire logic serial_transmit_request_i,
    input wire logic converter_request_i,
    input wire logic low_voltage_detector_i,
    input wire logic comparator_i,
    // raw port pins
    input wire logic [7:0] pin_i,
    // register port
    input wire virc_pkg::virc_req_t req_i,
    output logic [7:0] rdata_o,
    // cpu side
    input wire logic global_enable_i,
    input wire logic ack_i,
    input wire logic [3:0] ack_src_i,
    output virc_pkg::virc_vec_t vec_o,
    output logic irq_o
);
    import virc_pkg::*;

    // --------------------------------------------------------------
    // pin synchronisers and edge detect
    // --------------------------------------------------------------
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] shsel;

    // two flops before anything looks at a pin
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // rising edges; pins 6 and 7 may be replaced by shared sources
    logic [7:0] pin_evt;
    always_comb begin
        pin_evt = pin_s2 & ~pin_s3;
        if (shsel[7]) begin
            pin_evt[7] = low_voltage_detector_i;
        end
        if (shsel[6]) begin
            pin_evt[6] = comparator_i;
        end
    end

    // --------------------------------------------------------------
    // event vectors
    // --------------------------------------------------------------
    logic [7:0] evt0;
    logic [15:0] evt;
    always_comb begin
        evt0 = 8'h00;
        evt0[`VIRC_BIT_T1] = second_timer_request_i;
        evt0[`VIRC_BIT_T0] = first_timer_request_i;
        evt0[`VIRC_BIT_RX] = serial_receive_request_i;
        evt0[`VIRC_BIT_TX] = serial_transmit_request_i;
        evt0[`VIRC_BIT_ADC] = converter_request_i;
        evt = {pin_evt, evt0};
    end

    // --------------------------------------------------------------
    // register decode
    // --------------------------------------------------------------
    logic [15:0] pend;
    logic [7:0] phi0;
    logic [7:0] plo0;
    logic [7:0] pinhi;
    logic [7:0] pinlo;
    logic [7:0] imask;
    logic wr_pend0;
    logic wr_pend1;

    assign wr_pend0 = req_i.wr && req_i.addr == `VIRC_OFS_PEND0;
    assign wr_pend1 = req_i.wr && req_i.addr == `VIRC_OFS_PEND1;

    // priority, select and mask registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            phi0 <= `VIRC_RST_BYTE;
            plo0 <= `VIRC_RST_BYTE;
            pinhi <= `VIRC_RST_BYTE;
            pinlo <= `VIRC_RST_BYTE;
            shsel <= `VIRC_RST_BYTE;
            imask <= `VIRC_RST_BYTE;
        end else if (req_i.wr) begin
            unique case (req_i.addr)
                `VIRC_OFS_PHI0: phi0 <= req_i.wdata & `VIRC_BANK0_MASK;
                `VIRC_OFS_PLO0: plo0 <= req_i.wdata & `VIRC_BANK0_MASK;
                `VIRC_OFS_PINHI: pinhi <= req_i.wdata;
                `VIRC_OFS_PINLO: pinlo <= req_i.wdata;
                `VIRC_OFS_SSEL: shsel <= req_i.wdata & `VIRC_SSEL_MASK;
                `VIRC_OFS_IMASK: imask <= req_i.wdata;
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // pending flags, one per source
    // --------------------------------------------------------------
    logic [15:0] wclr;
    logic [15:0] aclr;
    logic [15:0] valid_mask;
    assign valid_mask = {8'hFF, `VIRC_BANK0_MASK};

    always_comb begin
        wclr = 16'h0000;
        aclr = 16'h0000;
        if (wr_pend0) begin
            wclr[7:0] = ~req_i.wdata;
        end
        if (wr_pend1) begin
            wclr[15:8] = ~req_i.wdata;
        end
        if (ack_i) begin
            aclr[ack_src_i] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_pend
            always_ff @(posedge core_clk_i) begin
                if (rst_i || !valid_mask[g]) begin
                    pend[g] <= 1'b0;
                end else if (evt[g]) begin
                    pend[g] <= 1'b1;
                end else if (wclr[g] || aclr[g]) begin
                    pend[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // priority levels and arbitration
    // --------------------------------------------------------------
    logic [31:0] level;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[2*i +: 2] = {phi0[i], plo0[i]};
            level[16 + 2*i +: 2] = {pinhi[i], pinlo[i]};
        end
    end

    logic found;
    logic [3:0] win;
    virc_arbiter #(.NSRC(16)) u_arb (
        .pend_i(pend),
        .level_i(level),
        .found_o(found),
        .idx_o(win)
    );

    // vector to cpu only while globally enabled
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vec_o <= '0;
        end else begin
            vec_o.valid <= found && global_enable_i;
            vec_o.source <= win;
        end
    end

    // --------------------------------------------------------------
    // summary interrupt from status and mask
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= global_enable_i && |(pend[7:0] & imask);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !req_i.rd) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (req_i.addr)
                `VIRC_OFS_PEND0: rdata_o <= pend[7:0];
                `VIRC_OFS_PEND1: rdata_o <= pend[15:8];
                `VIRC_OFS_PHI0: rdata_o <= phi0;
                `VIRC_OFS_PLO0: rdata_o <= plo0;
                `VIRC_OFS_PINHI: rdata_o <= pinhi;
                `VIRC_OFS_PINLO: rdata_o <= pinlo;
                `VIRC_OFS_SSEL: rdata_o <= shsel;
                `VIRC_OFS_IMASK: rdata_o <= imask;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // event patterns the flag logic must honour
    sequence s_evt_t1;
        second_timer_request_i;
    endsequence

    sequence s_evt_tx_with_clear;
        evt[`VIRC_BIT_TX] && wclr[`VIRC_BIT_TX];
    endsequence

    // an acknowledge that no fresh event overrides
    sequence s_ack_plain;
        ack_i && !evt[ack_src_i];
    endsequence

    // register port strobes
    sequence s_rd_pend0;
        req_i.rd && req_i.addr == `VIRC_OFS_PEND0;
    endsequence

    sequence s_wr_pinhi;
        req_i.wr && req_i.addr == `VIRC_OFS_PINHI;
    endsequence

    sequence s_wr_pinlo;
        req_i.wr && req_i.addr == `VIRC_OFS_PINLO;
    endsequence

    a_set_on_event: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_evt_t1 |=> pend[`VIRC_BIT_T1])
        else $error("timer flag not set");

    a_no_vec_off: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !global_enable_i |=> !vec_o.valid)
        else $error("vector while disabled");

    a_vec_when_on: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (found && global_enable_i) |=> vec_o.valid)
        else $error("vector missing");

    a_vec_source: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (found && global_enable_i) |=> vec_o.source == $past(win))
        else $error("vector source wrong");

    a_reserved_zero: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (pend[7:0] & ~`VIRC_BANK0_MASK) == 8'h00)
        else $error("reserved flag set");

    a_flag_holds: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (pend[`VIRC_BIT_T0] && !wclr[`VIRC_BIT_T0] && !aclr[`VIRC_BIT_T0])
        |=> pend[`VIRC_BIT_T0])
        else $error("flag dropped unserviced");

    a_no_stray_flag: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (!pend[`VIRC_BIT_RX] && !evt[`VIRC_BIT_RX]) |=> !pend[`VIRC_BIT_RX])
        else $error("flag set with no event");

    a_pend0_read: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_rd_pend0 |=> rdata_o == $past(pend[7:0]))
        else $error("pending read wrong");

    a_read_stands: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !req_i.rd |=> rdata_o == 8'h00)
        else $error("read data outlived its cycle");

    a_pinhi_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_wr_pinhi |=> pinhi == $past(req_i.wdata))
        else $error("pin high bits not stored");

    a_pinlo_write: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_wr_pinlo |=> pinlo == $past(req_i.wdata))
        else $error("pin low bits not stored");

    a_shared_lowvolt: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (shsel[7] && low_voltage_detector_i) |=> pend[15])
        else $error("low-voltage request lost");

    a_shared_comp: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (shsel[6] && comparator_i) |=> pend[14])
        else $error("comparator request lost");

    a_select_bits: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (shsel & ~`VIRC_SSEL_MASK) == 8'h00)
        else $error("unused select bit set");

    a_event_wins: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_evt_tx_with_clear |=> pend[`VIRC_BIT_TX])
        else $error("event lost to clear");

    a_ack_clears: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_ack_plain |=> !pend[$past(ack_src_i)])
        else $error("ack did not clear");

    a_disabled_off: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        found |-> level[2*win +: 2] != 2'h0)
        else $error("disabled source won");

    a_high_first: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (pend[8] && level[17:16] == 2'h3 && found) |->
        level[2*win +: 2] == 2'h3)
        else $error("lower level won");

    a_irq_when_on: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (global_enable_i && |(pend[7:0] & imask)) |=> irq_o)
        else $error("interrupt missing");

    a_irq_off: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !global_enable_i |=> !irq_o)
        else $error("interrupt while disabled");

    // each synchronised rise of a pin not taken over by a shared source lands in its flag
    for (genvar k = 0; k < 8; k++) begin : g_pin_chk
        sequence s_pin_rise;
            $rose(pin_s2[k]) && !shsel[k];
        endsequence

        a_pin_edge_set: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            s_pin_rise |=> pend[8 + k])
            else $error("pin edge lost");
    end
endmodule

`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the interrupt request controller
// assumes the cpu model is compiled before this file
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import virc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ge = 1'b0;
    logic take = 1'b0;
    logic got = 1'b0;
    logic ack;
    logic irq;
    logic [6:0] ev = '0;
    logic [7:0] pin = '0;
    logic [7:0] rd;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] p;
    logic [7:0] acc;
    logic [7:0] ex;
    logic [3:0] asrc;
    logic [3:0] first_src = '0;
    virc_req_t req = '0;
    virc_vec_t vec;
    int err_count = 0;
    int num_checks = 0;
    int sb[5] = '{6, 5, 4, 3, 0};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    virc_top dut (
        .core_clk_i(clk), .rst_i(rst), .second_timer_request_i(ev[6]),
        .first_timer_request_i(ev[5]), .serial_receive_request_i(ev[4]),
        .serial_transmit_request_i(ev[3]), .converter_request_i(ev[0]),
        .low_voltage_detector_i(ev[2]), .comparator_i(ev[1]),
        .pin_i(pin), .req_i(req), .rdata_o(rd), .global_enable_i(ge),
        .ack_i(ack), .ack_src_i(asrc), .vec_o(vec), .irq_o(irq)
    );

    virc_cpu_model #(.DLY(3)) cpu (
        .clk_i(clk), .rst_i(rst), .take_i(take), .vec_i(vec),
        .ack_o(ack), .ack_src_o(asrc)
    );

    // remember which source the cpu took first
    always @(posedge clk) begin
        if (ack && !got) begin
            first_src <= asrc;
            got <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // one strobe cycle, then one idle cycle
    task automatic bus(input logic [11:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge clk) req <= '{a, d, w, !w};
        @(posedge clk) req <= '0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        bus(a, 8'h00, 1'b0);
        #1 chk("rdata", e, rd);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= '0;
    endtask

    // highest level wins, lowest pin index on a tie
    function automatic logic [7:0] best(input logic [7:0] h, l, q);
        logic [1:0] top = 2'b00;
        best = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (q[i] && {h[i], l[i]} > top) begin
                top = {h[i], l[i]};
                best = 8'h18 + 8'(i);
            end
        end
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(65396));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(12'hFC0, 8'h00);
        rchk(12'hFC4, 8'h00);
        rchk(12'hFC5, 8'h00);
        acc = 8'h00;
        foreach (sb[k]) begin
            pulse(7'h01 << sb[k]);
            acc = acc | (8'h01 << sb[k]);
            rchk(12'hFC0, acc);
        end
        bus(12'hFC0, 8'h79, 1'b1);
        rchk(12'hFC0, 8'h79);
        @(posedge clk) begin
            req <= '{12'hFC0, 8'h00, 1'b1, 1'b0};
            ev <= 7'h08;
        end
        @(posedge clk) begin
            req <= '0;
            ev <= '0;
        end
        rchk(12'hFC0, 8'h08);
        bus(12'hFC8, 8'h08, 1'b1);
        @(posedge clk) ge <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        @(posedge clk) ge <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        rchk(12'hFC0, 8'h08);
        bus(12'hFC0, 8'h00, 1'b1);
        rchk(12'hFC0, 8'h00);
        for (int n = 0; n < 24; n++) begin
            hi = 8'($urandom);
            lo = 8'($urandom);
            p = 8'($urandom);
            if (n == 0) begin
                hi = 8'hFF;
                lo = 8'hFF;
                p = 8'hA0;
            end
            bus(12'hFC4, hi, 1'b1);
            bus(12'hFC5, lo, 1'b1);
            rchk(12'hFC4, hi);
            rchk(12'hFC5, lo);
            @(posedge clk) begin
                pin <= p;
                ge <= n[0];
            end
            repeat (8) @(posedge clk);
            ex = best(hi, lo, p);
            // the source field tracks the winner even while masked off
            #1 chk("vec", n[0] ? ex : ex & 8'h0F, {3'b0, vec});
            rchk(12'hFC3, p);
            @(posedge clk) pin <= '0;
            bus(12'hFC3, 8'h00, 1'b1);
        end
        pulse(7'h06);
        rchk(12'hFC3, 8'h00);
        bus(12'hFC6, 8'hC0, 1'b1);
        pulse(7'h06);
        rchk(12'hFC3, 8'hC0);
        bus(12'hFC3, 8'h00, 1'b1);
        bus(12'hFC1, 8'h40, 1'b1);
        bus(12'hFC2, 8'h60, 1'b1);
        pulse(7'h60);
        repeat (2) @(posedge clk);
        #1 chk("bank0 vec", 8'h16, {3'b0, vec});
        bus(12'hFC1, 8'h60, 1'b1);
        @(posedge clk);
        #1 chk("tie vec", 8'h15, {3'b0, vec});
        bus(12'hFC0, 8'h00, 1'b1);
        bus(12'hFC1, 8'h00, 1'b1);
        bus(12'hFC2, 8'h00, 1'b1);
        bus(12'hFC4, 8'h02, 1'b1);
        bus(12'hFC5, 8'h01, 1'b1);
        @(posedge clk) begin
            take <= 1'b1;
            ge <= 1'b1;
            pin <= 8'h03;
        end
        repeat (40) @(posedge clk);
        chk("first ack", 8'h09, {4'h0, first_src});
        rchk(12'hFC3, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: verif/virc_cpu_model.sv
// cpu core model that takes vectored requests and acknowledges them
// assumes vec_i is registered on clk_i; DLY sets how slowly it answers
`timescale 1ns/10ps
`default_nettype none

module virc_cpu_model #(
    parameter int DLY = 2
) (
    // clock, reset and mode
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic take_i,
    // vector from the controller
    input wire virc_pkg::virc_vec_t vec_i,
    // acknowledge back
    output logic ack_o,
    output logic [3:0] ack_src_o
);
    import virc_pkg::*;
    int cnt;

    // ----------------------------------------------------------------
    // acknowledge after DLY cycles, then hold off while the flag drops
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        ack_src_o <= ~ack_src_o; // idle source lines carry no meaning
        if (rst_i) begin
            cnt <= 0;
            ack_src_o <= 4'h0;
        end else if (!take_i) begin
            cnt <= 0;
        end else if (cnt < 0) begin
            cnt <= cnt + 1; // vec lags the flag, avoid a double ack
        end else if (vec_i.valid) begin
            if (cnt >= DLY) begin
                ack_o <= 1'b1;
                ack_src_o <= vec_i.source;
                cnt <= -4;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire
